/* File: hdl/stch_defines.vh */
// constants for the time code unit: register offsets, fields, responses
`ifndef STCH_DEFINES_VH
`define STCH_DEFINES_VH
// register byte offsets
`define STCH_OFF_LAST 12'h000
`define STCH_OFF_LISTEN 12'h004
`define STCH_OFF_SEND 12'h008
`define STCH_OFF_CFG 12'h00C
`define STCH_OFF_RESTART 12'h010
`define STCH_OFF_WD 12'h014
`define STCH_OFF_MATCH 12'h018
`define STCH_OFF_PI_RM 12'h01C
`define STCH_OFF_PI_RCM 12'h020
`define STCH_OFF_PI_R 12'h024
`define STCH_OFF_PI_RCS 12'h028
`define STCH_OFF_IM 12'h02C
`define STCH_OFF_PI_C 12'h030
`define STCH_OFF_IM_S 12'h034
`define STCH_OFF_IM_C 12'h038
// last code register fields
`define STCH_LAST_SEND_BIT 8
// restart register fields
`define STCH_RST_SRC_LSB 8
`define STCH_RST_ONE_BIT 12
// watchdog register fields: early in 15:0, late in 31:16
`define STCH_WD_LATE_LSB 16
// match register fields: value 5:0, mask 13:8
`define STCH_MATCH_MASK_LSB 8
// interrupt bits
`define STCH_IRQ_EARLY 0
`define STCH_IRQ_LATE 1
`define STCH_IRQ_CODE 2
`define STCH_IRQ_SYNC 3
`define STCH_IRQ_MATCH 4
`define STCH_IRQ_W 5
// event source codes (0 = none)
`define STCH_SRC_NONE 2'h0
`define STCH_SRC_CAL0 2'h1
`define STCH_SRC_CAL1 2'h2
`define STCH_SRC_EXTRA 2'h3
// restart delay in link logic clock cycles, inside 2..3
`define STCH_RESTART_DLY 2'h2
// axi responses
`define STCH_RESP_OKAY 2'h0
`define STCH_RESP_SLVERR 2'h2
`endif

/* File: hdl/stch_time_code_unit.v */
// time code unit: time code counter, sender, listener, watchdogs, irqs
// How it works
// - six-bit code counts 0..63 and wraps
// - arriving code valid when last plus one
// - every arriving code overwrites the last value
// - listen and master sources work together
// - send or listen on any link subset
// - bit 0 is link 1, bit 1 link 2
// - sync event with code to packet units
// - master select picks calendar event output
// - master event increments then sends on links
// - manual send bit sends one incremented code
// - restart copies value two cycles after event
// - restart sources add one extra calendar input
// - single restart acts on first event only
// - accepted codes repeated on send links
// - valid code before early limit flags early
// - no valid code by late limit flags late
// - only valid codes restart both watchdogs
// - every valid code sets valid-code flag
// - masked bits equal gives code-match flag
// - sync event also flagged as interrupt
// - pending and mask seen at several aliases
// - plain read alias, read-and-clear alias
// - read-clear alias also sets on write
// - clear-only alias clears written ones
// - mask rw, set-only and clear-only aliases
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`include "stch_defines.vh"
module stch_time_code_unit (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // axi4-lite write address
   input wire awvalid_i,
   output wire awready_o,
   input wire [11:0] awaddr_i,
   input wire [2:0] awprot_i,
   // axi4-lite write data
   input wire wvalid_i,
   output wire wready_o,
   input wire [31:0] wdata_i,
   input wire [3:0] wstrb_i,
   // axi4-lite write response
   output reg bvalid_o,
   input wire bready_i,
   output reg [1:0] bresp_o,
   // axi4-lite read address
   input wire arvalid_i,
   output wire arready_o,
   input wire [11:0] araddr_i,
   input wire [2:0] arprot_i,
   // axi4-lite read data
   input wire rready_i,
   output reg rvalid_o,
   output reg [31:0] rdata_o,
   output reg [1:0] rresp_o,
   // calendar events, one-cycle pulses
   input wire [1:0] cal_event_i,
   input wire cal_extra_i,
   // link receive side: code strobes per link
   input wire [1:0] link_rx_valid_i,
   input wire [5:0] link1_rx_code_i,
   input wire [5:0] link2_rx_code_i,
   // link send side
   output reg [1:0] link_tx_valid_o,
   output reg [5:0] link_tx_code_o,
   // sync event to packet transmitters and receivers
   output reg sync_event_o,
   output reg [5:0] sync_code_o,
   // interrupt
   output wire irq_o
);

   // --- registers ---
   reg [5:0] last_code_value_q; // current time code
   reg [1:0] listen_link_select_q; // bit 0 link 1
   reg [1:0] send_link_select_q; // bit 0 link 1
   reg [1:0] master_event_select_q; // source code
   reg [5:0] restart_value_q; // value loaded on restart
   reg [1:0] restart_src_q; // restart source code
   reg single_restart_q; // restart only once
   reg restart_done_q; // single restart already used
   reg [15:0] early_limit_q; // cycles before which code is early
   reg [15:0] late_limit_q; // cycles by which code must come
   reg [5:0] match_value_q;
   reg [5:0] match_mask_q;
   reg [`STCH_IRQ_W-1:0] pend_q; // pending interrupt bits
   reg [`STCH_IRQ_W-1:0] mask_q; // interrupt mask bits
   reg [15:0] wd_cnt_q; // cycles since last valid code
   reg late_armed_q; // late flag given once per window
   reg [1:0] rst_dly_q; // restart delay count, 0 = idle
   reg manual_q; // manual send requested

   // bus handshake state
   reg aw_have_q;
   reg [11:0] aw_addr_q;
   reg w_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   // select one event source by code
   function src_hit;
      input [1:0] sel;
      input [1:0] cal;
      input extra;
      begin
         case (sel)
            `STCH_SRC_CAL0: src_hit = cal[0];
            `STCH_SRC_CAL1: src_hit = cal[1];
            `STCH_SRC_EXTRA: src_hit = extra;
            default: src_hit = 1'b0;
         endcase
      end
   endfunction

   // apply byte strobes to a word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   // --- bus handshakes: address and data taken in any order ---
   wire wr_go = aw_have_q && w_have_q && !bvalid_o;
   assign awready_o = !aw_have_q;
   assign wready_o = !w_have_q;
   // one read at a time: refuse new address while answer stands
   assign arready_o = !rvalid_o;
   wire rd_go = arvalid_i && arready_o;

   // read side effects decoded once
   wire rd_clr = rd_go && (araddr_i == `STCH_OFF_PI_RCM ||
      araddr_i == `STCH_OFF_PI_RCS);

   // write data with strobes applied to zero, for set/clear aliases
   wire [31:0] wbits = merge(32'h0, w_data_q, w_strb_q);

   // --- receive path: first enabled link wins a tie ---
   wire [1:0] rx_hit = link_rx_valid_i & listen_link_select_q;
   wire rx_any = |rx_hit;
   wire [5:0] rx_code = rx_hit[0] ? link1_rx_code_i : link2_rx_code_i;
   wire [5:0] next_code = last_code_value_q + 6'h1;
   wire rx_valid = rx_any && (rx_code == next_code);

   // master trigger: calendar event or manual request
   wire mst_ev = src_hit(master_event_select_q, cal_event_i,
      1'b0);
   wire mst_go = mst_ev || manual_q;
   // restart trigger adds the extra calendar input
   wire rst_ev = src_hit(restart_src_q, cal_event_i, cal_extra_i) &&
      !(single_restart_q && restart_done_q);

   // a code emitted or accepted this cycle
   wire code_new = mst_go || rx_valid;
   wire [5:0] code_out = next_code;
   wire is_match = ((code_out ^ match_value_q) & match_mask_q) == 6'h0;

   // interrupt events this cycle
   reg [`STCH_IRQ_W-1:0] ev;
   always @* begin
      ev = {`STCH_IRQ_W{1'b0}};
      ev[`STCH_IRQ_EARLY] = rx_valid && !mst_go &&
         (wd_cnt_q < early_limit_q);
      ev[`STCH_IRQ_LATE] = late_armed_q && !code_new &&
         (wd_cnt_q >= late_limit_q);
      ev[`STCH_IRQ_CODE] = code_new;
      ev[`STCH_IRQ_SYNC] = code_new;
      ev[`STCH_IRQ_MATCH] = code_new && is_match;
   end

   assign irq_o = |(pend_q & mask_q);

   // --- bus write channel state ---
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_have_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_o <= 1'b0;
         bresp_o <= `STCH_RESP_OKAY;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata_i;
            w_strb_q <= wstrb_i;
         end
         if (wr_go) begin
            // both halves held: perform write, answer next cycle
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o <= (aw_addr_q[1:0] != 2'h0 ||
               aw_addr_q > `STCH_OFF_IM_C) ?
               `STCH_RESP_SLVERR : `STCH_RESP_OKAY;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   // --- bus read channel: plain reads and alias side effects ---
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_o <= 1'b0;
         rdata_o <= 32'h00000000;
         rresp_o <= `STCH_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_o <= 1'b1;
         rresp_o <= `STCH_RESP_OKAY;
         rdata_o <= 32'h00000000;
         if (araddr_i == `STCH_OFF_LAST) begin
            rdata_o <= {26'h0, last_code_value_q};
         end else if (araddr_i == `STCH_OFF_LISTEN) begin
            rdata_o <= {30'h0, listen_link_select_q};
         end else if (araddr_i == `STCH_OFF_SEND) begin
            rdata_o <= {30'h0, send_link_select_q};
         end else if (araddr_i == `STCH_OFF_CFG) begin
            rdata_o <= {30'h0, master_event_select_q};
         end else if (araddr_i == `STCH_OFF_RESTART) begin
            rdata_o <= {19'h0, single_restart_q, 2'h0, restart_src_q,
               2'h0, restart_value_q};
         end else if (araddr_i == `STCH_OFF_WD) begin
            rdata_o <= {late_limit_q, early_limit_q};
         end else if (araddr_i == `STCH_OFF_MATCH) begin
            rdata_o <= {18'h0, match_mask_q, 2'h0, match_value_q};
         end else if (araddr_i == `STCH_OFF_PI_RM ||
            araddr_i == `STCH_OFF_PI_RCM ||
            araddr_i == `STCH_OFF_PI_R ||
            araddr_i == `STCH_OFF_PI_RCS) begin
            rdata_o <= {27'h0, pend_q};
         end else if (araddr_i == `STCH_OFF_IM) begin
            rdata_o <= {27'h0, mask_q};
         end else if (araddr_i == `STCH_OFF_PI_C ||
            araddr_i == `STCH_OFF_IM_S ||
            araddr_i == `STCH_OFF_IM_C) begin
            rdata_o <= 32'h00000000; // write-only aliases read zero
         end else begin
            rresp_o <= `STCH_RESP_SLVERR; // unmapped
         end
      end else if (rvalid_o && rready_i) begin
         rvalid_o <= 1'b0;
      end
   end

   // --- configuration registers written by software ---
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         listen_link_select_q <= 2'h0;
         send_link_select_q <= 2'h0;
         master_event_select_q <= `STCH_SRC_NONE;
         restart_value_q <= 6'h00;
         restart_src_q <= `STCH_SRC_NONE;
         single_restart_q <= 1'b0;
         early_limit_q <= 16'h0000;
         late_limit_q <= 16'hFFFF;
         match_value_q <= 6'h00;
         match_mask_q <= 6'h00;
         mask_q <= {`STCH_IRQ_W{1'b0}};
      end else if (wr_go) begin
         if (aw_addr_q == `STCH_OFF_LISTEN) begin
            listen_link_select_q <= w_data_q[1:0];
         end else if (aw_addr_q == `STCH_OFF_SEND) begin
            send_link_select_q <= w_data_q[1:0];
         end else if (aw_addr_q == `STCH_OFF_CFG) begin
            master_event_select_q <= w_data_q[1:0];
         end else if (aw_addr_q == `STCH_OFF_RESTART) begin
            restart_value_q <= w_data_q[5:0];
            restart_src_q <= w_data_q[`STCH_RST_SRC_LSB +: 2];
            single_restart_q <= w_data_q[`STCH_RST_ONE_BIT];
         end else if (aw_addr_q == `STCH_OFF_WD) begin
            {late_limit_q, early_limit_q} <=
               merge({late_limit_q, early_limit_q}, w_data_q, w_strb_q);
         end else if (aw_addr_q == `STCH_OFF_MATCH) begin
            match_value_q <= w_data_q[5:0];
            match_mask_q <= w_data_q[`STCH_MATCH_MASK_LSB +: 6];
         end else if (aw_addr_q == `STCH_OFF_IM) begin
            mask_q <= wbits[`STCH_IRQ_W-1:0];
         end else if (aw_addr_q == `STCH_OFF_IM_S) begin
            mask_q <= mask_q | wbits[`STCH_IRQ_W-1:0];
         end else if (aw_addr_q == `STCH_OFF_IM_C) begin
            mask_q <= mask_q & ~wbits[`STCH_IRQ_W-1:0];
         end
      end
   end

   // --- pending bits: hardware set wins over any clear ---
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q <= {`STCH_IRQ_W{1'b0}};
      end else begin
         if (rd_clr) begin
            pend_q <= ev;
         end else if (wr_go && aw_addr_q == `STCH_OFF_PI_RCS) begin
            pend_q <= pend_q | ev | wbits[`STCH_IRQ_W-1:0];
         end else if (wr_go && aw_addr_q == `STCH_OFF_PI_C) begin
            pend_q <= (pend_q & ~wbits[`STCH_IRQ_W-1:0]) | ev;
         end else begin
            pend_q <= pend_q | ev;
         end
      end
   end

   // --- time code core: counter, restart, manual send, watchdog ---
   // restart copy is delayed so a master event on the same source
   // increments and sends first, then the restart value lands
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_code_value_q <= 6'h00;
         manual_q <= 1'b0;
         rst_dly_q <= 2'h0;
         restart_done_q <= 1'b0;
         wd_cnt_q <= 16'h0000;
         late_armed_q <= 1'b1;
      end else begin
         // a new restart setting re-arms the single restart
         if (wr_go && aw_addr_q == `STCH_OFF_RESTART) begin
            restart_done_q <= 1'b0;
         end
         // restart delay chain
         if (rst_ev && rst_dly_q == 2'h0) begin
            rst_dly_q <= `STCH_RESTART_DLY;
            restart_done_q <= 1'b1;
         end else if (rst_dly_q != 2'h0) begin
            rst_dly_q <= rst_dly_q - 2'h1;
         end
         // manual request is consumed by the send it causes
         if (manual_q) begin
            manual_q <= 1'b0;
         end
         // software writes to the last code register
         if (wr_go && aw_addr_q == `STCH_OFF_LAST) begin
            if (w_data_q[`STCH_LAST_SEND_BIT]) begin
               manual_q <= 1'b1;
            end
         end
         if (rst_dly_q == 2'h1) begin
            last_code_value_q <= restart_value_q;
         end else if (mst_go) begin
            last_code_value_q <= next_code;
         end else if (rx_any) begin
            last_code_value_q <= rx_code;
         end else if (wr_go && aw_addr_q == `STCH_OFF_LAST) begin
            last_code_value_q <= w_data_q[5:0];
         end
         // watchdog counts from the last valid code
         if (code_new) begin
            wd_cnt_q <= 16'h0000;
            late_armed_q <= 1'b1;
         end else begin
            if (wd_cnt_q != 16'hFFFF) begin
               wd_cnt_q <= wd_cnt_q + 16'h0001;
            end
            if (ev[`STCH_IRQ_LATE]) begin
               late_armed_q <= 1'b0; // one late flag per gap
            end
         end
      end
   end

   // --- outgoing codes and sync event ---
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_tx_valid_o <= 2'h0;
         link_tx_code_o <= 6'h00;
         sync_event_o <= 1'b0;
         sync_code_o <= 6'h00;
      end else begin
         link_tx_valid_o <= code_new ? send_link_select_q :
            2'h0;
         sync_event_o <= code_new;
         if (code_new) begin
            link_tx_code_o <= code_out;
            sync_code_o <= code_out;
         end
      end
   end

endmodule

/* File: test/stch_link_model.sv */
// model of the link handlers and packet units around the time code unit
module stch_link_model (
   // clock
   input wire clock_i,
   // codes arriving from the links
   output logic [1:0] link_rx_valid_o,
   output logic [5:0] link1_rx_code_o,
   output logic [5:0] link2_rx_code_o,
   // codes sent on the links and sync events
   input wire [1:0] link_tx_valid_i,
   input wire [5:0] link_tx_code_i,
   input wire sync_event_i,
   input wire [5:0] sync_code_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // sends counted per link, last codes seen
   int tx1_cnt = 0;
   int tx2_cnt = 0;
   logic [5:0] tx_code = 6'h00;
   logic [5:0] sync_code = 6'h00;
   // lines quiet at start
   initial begin
      link_rx_valid_o = 2'h0;
      link1_rx_code_o = 6'h00;
      link2_rx_code_o = 6'h00;
   end
   // record sends; bit 0 is link 1, bit 1 link 2
   always @(posedge clock_i) begin
      if (link_tx_valid_i[0]) tx1_cnt <= tx1_cnt + 1;
      if (link_tx_valid_i[1]) tx2_cnt <= tx2_cnt + 1;
      if (link_tx_valid_i != 2'h0) tx_code <= link_tx_code_i;
      if (sync_event_i) sync_code <= sync_code_i;
   end
   // one code on one link (0 is link 1); the code line is then inverted
   // so a stale value can never pass for a fresh one
   task automatic send_code(input int lnk, input logic [5:0] c);
      @(posedge clock_i);
      link_rx_valid_o <= (lnk == 0) ? 2'h1 : 2'h2;
      if (lnk == 0) link1_rx_code_o <= c;
      else link2_rx_code_o <= c;
      @(posedge clock_i);
      link_rx_valid_o <= 2'h0;
      if (lnk == 0) link1_rx_code_o <= ~c;
      else link2_rx_code_o <= ~c;
      repeat (3) @(posedge clock_i);
   endtask
endmodule

/* File: test/stch_time_code_unit_properties.sv */
// checker of handshake and event timing at the time code unit ports
`include "stch_defines.vh"
module stch_tcu_props (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // write channels
   input wire awvalid_i,
   input wire awready_o,
   input wire wvalid_i,
   input wire wready_o,
   input wire bvalid_o,
   input wire bready_i,
   input wire [1:0] bresp_o,
   // read channels
   input wire arvalid_i,
   input wire arready_o,
   input wire rready_i,
   input wire rvalid_o,
   input wire [31:0] rdata_o,
   input wire [1:0] rresp_o,
   // link and sync outputs
   input wire [1:0] link_tx_valid_o,
   input wire sync_event_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // both write halves taken at one edge
   sequence s_aw_w;
      awvalid_i && awready_o && wvalid_i && wready_o && !bvalid_o;
   endsequence
   // response offered but not yet accepted
   sequence s_b_wait;
      bvalid_o && !bready_i;
   endsequence
   a_write_answer: assert property (s_aw_w |-> ##2 bvalid_o)
      else $error("write response not two edges after capture");
   a_aw_drop: assert property (awvalid_i && awready_o |=> !awready_o)
      else $error("address ready stayed high after capture");
   a_b_hold: assert property (s_b_wait |=> bvalid_o && $stable(bresp_o))
      else $error("write response dropped before acceptance");
   a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
      else $error("read data not one edge after address");
   a_ar_block: assert property (rvalid_o |-> !arready_o)
      else $error("read address accepted while data pending");
   a_r_hold: assert property (rvalid_o && !rready_i |=>
      rvalid_o && $stable(rdata_o))
      else $error("read data changed before acceptance");
   a_err_zero: assert property (rvalid_o &&
      rresp_o == `STCH_RESP_SLVERR |-> rdata_o == 32'h0)
      else $error("refused read returned nonzero data");
   a_tx_sync: assert property (link_tx_valid_o != 2'h0 |-> sync_event_o)
      else $error("code sent without sync event");
   a_sync_pulse: assert property (sync_event_o |=> !sync_event_o)
      else $error("sync event longer than one cycle");
   a_tx_pulse: assert property (link_tx_valid_o != 2'h0 |=>
      link_tx_valid_o == 2'h0)
      else $error("send strobe longer than one cycle");
endmodule
bind stch_time_code_unit stch_tcu_props u_props (.clock_i, .rst_n_i,
   .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o, .bready_i,
   .bresp_o, .arvalid_i, .arready_o, .rready_i, .rvalid_o, .rdata_o,
   .rresp_o, .link_tx_valid_o, .sync_event_o);

/* File: test/stch_time_code_unit_tb.sv */
// self-checking bench for the time code unit
`include "stch_defines.vh"
module stch_time_code_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // clock, reset and driven inputs
   logic clock_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
   logic cal_extra;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [1:0] cal_event, rr;
   // design outputs and link lines
   wire awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
   wire sync_event_o;
   wire [1:0] bresp_o, rresp_o, link_tx_valid_o, rx_valid;
   wire [31:0] rdata_o;
   wire [5:0] link_tx_code_o, sync_code_o, rx1_code, rx2_code;
   // tallies
   int miscompares = 0;
   int check_count = 0;
   stch_time_code_unit uut (.clock_i, .rst_n_i, .awvalid_i(awvalid),
      .awready_o, .awaddr_i(awaddr), .awprot_i(3'h0), .wvalid_i(wvalid),
      .wready_o, .wdata_i(wdata), .wstrb_i(4'hF), .bvalid_o,
      .bready_i(bready), .bresp_o, .arvalid_i(arvalid), .arready_o,
      .araddr_i(araddr), .arprot_i(3'h0), .rready_i(rready), .rvalid_o,
      .rdata_o, .rresp_o, .cal_event_i(cal_event), .cal_extra_i(cal_extra),
      .link_rx_valid_i(rx_valid), .link1_rx_code_i(rx1_code),
      .link2_rx_code_i(rx2_code), .link_tx_valid_o, .link_tx_code_o,
      .sync_event_o, .sync_code_o, .irq_o);
   stch_link_model lnk (.clock_i, .link_rx_valid_o(rx_valid),
      .link1_rx_code_o(rx1_code), .link2_rx_code_o(rx2_code),
      .link_tx_valid_i(link_tx_valid_o), .link_tx_code_i(link_tx_code_o),
      .sync_event_i(sync_event_o), .sync_code_i(sync_code_o));
   // 10 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   // compare one word
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask
   // verdict and end of run
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // bus write; handshakes sampled at the falling edge before the rise
   // that takes them, so no race with the design's own updates
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      int n;
      n = 0;
      b_ok = 1'b0;
      @(posedge clock_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok && n < 50) begin
         @(negedge clock_i);
         aw_ok = awvalid & awready_o;
         w_ok = wvalid & wready_o;
         b_ok = bvalid_o & bready;
         rr = bresp_o;
         @(posedge clock_i);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         bready <= !b_ok;
         n++;
      end
      if (!b_ok) miscompares++;
   endtask
   // bus read into rd and rr; ready held up until the answer
   task automatic axi_rd(input logic [11:0] a);
      logic ar_ok, r_ok;
      int n;
      n = 0;
      r_ok = 1'b0;
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_ok && n < 50) begin
         @(negedge clock_i);
         ar_ok = arvalid & arready_o;
         r_ok = rvalid_o & rready;
         rd = rdata_o;
         rr = rresp_o;
         @(posedge clock_i);
         if (ar_ok) arvalid <= 1'b0;
         rready <= !r_ok;
         n++;
      end
      if (!r_ok) miscompares++;
   endtask
   // one-cycle calendar event pulse, then let it settle
   task automatic pulse(input logic [1:0] c, input logic e);
      @(posedge clock_i);
      cal_event <= c;
      cal_extra <= e;
      @(posedge clock_i);
      cal_event <= 2'h0;
      cal_extra <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask
   // master sends on both links with wrap
   task automatic t_master;
      axi_rd(`STCH_OFF_WD);
      chk_word(rd, 32'hFFFF0000);
      axi_wr(`STCH_OFF_SEND, 32'h3);
      axi_wr(`STCH_OFF_CFG, 32'h1);
      axi_wr(`STCH_OFF_LAST, 32'h3E);
      pulse(2'h1, 1'b0);
      chk_word(32'(lnk.tx2_cnt), 32'h1); // link 2 sent
      chk_word({26'h0, lnk.tx_code}, 32'h3F); // incremented
      chk_word({26'h0, lnk.sync_code}, 32'h3F); // sync code
      pulse(2'h2, 1'b0);
      chk_word(32'(lnk.tx1_cnt), 32'h1); // other output idle
      pulse(2'h1, 1'b0);
      chk_word({26'h0, lnk.tx_code}, 32'h0); // wraps
      axi_rd(`STCH_OFF_PI_RCM);
      chk_word(rd & 32'hC, 32'hC); // code, sync
      axi_rd(`STCH_OFF_PI_RM);
      chk_word(rd, 32'h0); // cleared by read
   endtask
   // software send with no event
   task automatic t_manual;
      axi_wr(`STCH_OFF_CFG, 32'h0);
      axi_wr(`STCH_OFF_LAST, 32'h105);
      repeat (4) @(posedge clock_i);
      chk_word({26'h0, lnk.tx_code}, 32'h6); // one sent
      chk_word(32'(lnk.tx1_cnt), 32'h3); // once only
   endtask
   // listening on link 2, repeating on link 1
   task automatic t_listen;
      axi_wr(`STCH_OFF_LISTEN, 32'h2);
      axi_wr(`STCH_OFF_SEND, 32'h1);
      axi_wr(`STCH_OFF_MATCH, 32'h3F08);
      axi_rd(`STCH_OFF_PI_RCM);
      lnk.send_code(0, 6'h07);
      chk_word(32'(lnk.tx1_cnt), 32'h3); // unlistened link
      lnk.send_code(1, 6'h07);
      chk_word(32'(lnk.tx1_cnt), 32'h4); // repeated
      chk_word(32'(lnk.tx2_cnt), 32'h3); // link 2 quiet
      axi_rd(`STCH_OFF_PI_RCM);
      chk_word(rd & 32'h14, 32'h4); // code, no match
      lnk.send_code(1, 6'h07);
      chk_word(32'(lnk.tx1_cnt), 32'h4); // repeat invalid
      lnk.send_code(1, 6'h08);
      axi_rd(`STCH_OFF_PI_RCM);
      chk_word(rd & 32'h14, 32'h14); // match
      lnk.send_code(1, 6'h14);
      lnk.send_code(1, 6'h15);
      chk_word({26'h0, lnk.tx_code}, 32'h15); // stored anyway
   endtask
   // early and late watchdogs
   task automatic t_watch;
      axi_wr(`STCH_OFF_WD, 32'h0064001E);
      lnk.send_code(1, 6'h16);
      axi_rd(`STCH_OFF_PI_RCM);
      lnk.send_code(1, 6'h17);
      axi_rd(`STCH_OFF_PI_RCM);
      chk_word(rd & 32'h1, 32'h1); // early flag
      repeat (60) @(posedge clock_i);
      lnk.send_code(1, 6'h28);
      repeat (55) @(posedge clock_i);
      axi_rd(`STCH_OFF_PI_RCM);
      chk_word(rd & 32'h3, 32'h2); // late
   endtask
   // pending and mask aliases, interrupt line, unmapped read
   task automatic t_alias;
      axi_wr(`STCH_OFF_PI_RM, 32'h1F);
      axi_wr(`STCH_OFF_PI_RCS, 32'h1);
      axi_rd(`STCH_OFF_PI_R);
      chk_word(rd, 32'h1); // forced bit
      chk_word({31'h0, irq_o}, 32'h0); // masked off
      axi_wr(`STCH_OFF_IM_S, 32'h1);
      chk_word({31'h0, irq_o}, 32'h1); // set alias
      axi_wr(`STCH_OFF_IM_C, 32'h1);
      chk_word({31'h0, irq_o}, 32'h0); // clear alias
      axi_wr(`STCH_OFF_IM, 32'h1);
      axi_rd(`STCH_OFF_IM);
      chk_word(rd, 32'h1); // plain mask
      axi_wr(`STCH_OFF_PI_C, 32'h1);
      chk_word({31'h0, irq_o}, 32'h0); // cleared
      axi_rd(12'h03C);
      chk_word({rr, rd[29:0]}, {`STCH_RESP_SLVERR, 30'h0});
      axi_wr(12'h03C, 32'h1);
      chk_word({30'h0, rr}, {30'h0, `STCH_RESP_SLVERR});
   endtask
   // restart after a master event, then single restart
   task automatic t_restart;
      axi_wr(`STCH_OFF_CFG, 32'h1);
      axi_wr(`STCH_OFF_RESTART, 32'h0128);
      axi_wr(`STCH_OFF_LAST, 32'h5);
      pulse(2'h1, 1'b0);
      chk_word({26'h0, lnk.tx_code}, 32'h6); // master first
      axi_rd(`STCH_OFF_LAST);
      chk_word(rd & 32'h3F, 32'h28); // copied later
      lnk.send_code(1, 6'h29);
      chk_word({26'h0, lnk.tx_code}, 32'h29); // mixed roles
      axi_wr(`STCH_OFF_RESTART, 32'h1328);
      pulse(2'h0, 1'b1);
      axi_rd(`STCH_OFF_LAST);
      chk_word(rd & 32'h3F, 32'h28); // extra input
      axi_wr(`STCH_OFF_LAST, 32'h5);
      pulse(2'h0, 1'b1);
      axi_rd(`STCH_OFF_LAST);
      chk_word(rd & 32'h3F, 32'h5); // once only
   endtask
   // main sequence
   initial begin
      rst_n_i = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, cal_extra} = 6'h00;
      {awaddr, araddr, wdata, cal_event} = 58'h0;
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_master;
      t_manual;
      t_listen;
      t_watch;
      t_alias;
      t_restart;
      close_out;
   end
   // hang guard, nearly sixty times the expected run
   initial begin
      #2000000;
      miscompares++;
      close_out;
   end
endmodule
